// *** common/pic_defs.svh ***
// register offsets, field positions and timing counts of the interrupt controller
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH
`define PIC_OFF_CLR0      8'hDA
`define PIC_OFF_CLR1      8'hDB
`define PIC_OFF_CLR2      8'hDC
`define PIC_OFF_MSK3      8'hDE
`define PIC_OFF_MSK2      8'hDF
`define PIC_OFF_MSK1      8'hE0
`define PIC_OFF_MSK0      8'hE1
`define PIC_OFF_VC        8'hE2
`define PIC_OFF_CPUCTL    8'hE4
`define PIC_OFF_PCSTAT    8'hE5
`define PIC_SWPOST_BIT    7
`define PIC_RST_BYTE      8'h00
`define PIC_DISPATCH_CYC  5'h0D
`define PIC_LONG_JUMP_OP_CYC      5'h07
`define PIC_VEC_SHIFT     2
`define PIC_NUM_SRC       24
`endif

// *** common/pic_pkg.sv ***
// types shared by the interrupt controller
package pic_pkg;
  typedef enum logic [2:0] {
    PIC_IDLE  = 3'b000,
    PIC_PUSHH = 3'b001,
    PIC_PUSHL = 3'b011,
    PIC_PUSHF = 3'b010,
    PIC_WAIT  = 3'b110,
    PIC_JUMP  = 3'b111,
    PIC_RUN   = 3'b101
  } pic_state_t;

  typedef struct packed {
    logic       valid;
    logic       isWrite;
    logic [7:0] data;
  } pic_push_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       read;
    logic       write;
    logic [7:0] wdata;
  } pic_bus_t;
endpackage : pic_pkg

// *** logic/pic_prio_enc.sv ***
// priority encoder: lowest-numbered pending source wins
`timescale 1ns/1ps
`include "pic_defs.svh"
module pic_prio_enc #(
  parameter int NSRC = 24
) (
  input  wire logic [NSRC-1:0] pendVec,  // pending requests, bit 0 = priority 1
  output logic                 anyPend,  // at least one pending
  output logic [7:0]           vector    // vector of the winner, priority*4
);
  import pic_pkg::*;
  always_comb begin
    anyPend = 1'b0;
    vector  = `PIC_RST_BYTE;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pendVec[i]) begin
        anyPend = 1'b1;
        vector  = 8'((i + 1) << `PIC_VEC_SHIFT);
      end
    end
  end
endmodule : pic_prio_enc

// *** logic/pic_controller.sv ***
// prioritised interrupt controller with dispatch sequencer and avalon-mm slave
//
// Notes on behaviour
// - source event always sets its posted latch
// - latch holds until taken or cleared
// - masked-in posted sources become pending
// - highest pending taken only while enabled
// - mask never clears nor blocks posting
// - request activates on event, unmask, enable
// - finish instruction, then 13-cycle dispatch
// - push pc high, pc low, flags
// - flags cleared with the flags push
// - pc high zeroed, low gets vector
// - return restores pc and flags
// - pending requests dispatched before next instruction
// - latency is finish plus 13 plus 7
// - clear register reads return posted latches
// - enable low: zeros clear, ones ignored
// - enable high: zeros ignored, ones post
// - each mask bit gates its own source
// - priority 1 highest, vector is four times
// - vector register reads winner, write clears pending
`timescale 1ns/1ps
`include "pic_defs.svh"
module pic_controller
  import pic_pkg::*;
#(
  parameter int NSRC = `PIC_NUM_SRC
) (
  input  wire logic            clk,            // system clock, 10 MHz
  input  wire logic            sys_rst,        // async reset, active high
  input  wire logic [7:0]      avs_address,    // register byte address
  input  wire logic            avs_read,       // read strobe
  input  wire logic            avs_write,      // write strobe
  input  wire logic [31:0]     avs_writedata,  // write data, low byte used
  output logic [31:0]          avs_readdata,   // read data
  output logic                 avs_waitrequest,// stall
  input  wire logic [NSRC-1:0] srcEvent,       // one-cycle source conditions
  input  wire logic            instrDone,      // cpu finished current instruction
  input  wire logic            retiExec,       // return_from_irq_op executing
  input  wire logic [15:0]     cpuPc,          // cpu_program_counter now
  input  wire logic [7:0]      cpuFlags,       // cpu flag register now
  input  wire logic [7:0]      popPcHigh,      // popped pc_high_byte
  input  wire logic [7:0]      popPcLow,       // popped pc_low_byte
  input  wire logic [7:0]      popFlags,       // popped flag register
  output pic_push_t            stackPush,      // stack write strobe and byte
  output logic                 flagsClear,     // clear whole flag register
  output logic                 pcLoad,         // load pc
  output logic [15:0]          pcValue,        // pc value to load
  output logic                 flagsLoad,      // load flag register
  output logic [7:0]           flagsValue,     // flag value to load
  output logic                 dispatchBusy,   // dispatch holds the cpu
  output logic                 isrStart        // one pulse when isr begins
);
  import pic_pkg::*;

  // ************************************
  // state
  // ************************************
  typedef struct packed {
    logic [NSRC-1:0] posted;
    logic [NSRC-1:0] mask;
    logic            swPostEn;
    logic            global_irq_enable;
    logic            busy;
    pic_state_t      st;
    logic [4:0]      cnt;
    logic [7:0]      vec;
    logic [15:0]     savedPc;
    logic [7:0]      savedFl;
    pic_push_t       push;
    logic            fClr;
    logic            pLoad;
    logic [15:0]     pVal;
    logic            fLoad;
    logic [7:0]      fVal;
    logic            isrGo;
    logic            ack;
    logic [31:0]     rdata;
  } pic_regs_t;

  pic_regs_t cur_r;
  pic_regs_t cur_nxt;

  logic [NSRC-1:0] pending;
  logic            anyPend;
  logic [7:0]      winVec;
  logic [NSRC-1:0] takenBit;
  pic_bus_t        bus;

  assign bus.addr  = avs_address;
  assign bus.read  = avs_read;
  assign bus.write = avs_write;
  assign bus.wdata = avs_writedata[7:0];

  assign pending = cur_r.posted & cur_r.mask;

  // one-hot latch of the request being taken, bit 0 = priority 1
  assign takenBit = {{(NSRC-1){1'b0}}, 1'b1} << ((cur_r.vec >> `PIC_VEC_SHIFT) - 8'h01);

  pic_prio_enc #(.NSRC(NSRC)) u_enc (
    .pendVec (pending),
    .anyPend (anyPend),
    .vector  (winVec)
  );

  function automatic logic [1:0] clrIdx(input logic [7:0] a);
    clrIdx = 2'(a - `PIC_OFF_CLR0);
  endfunction : clrIdx

  function automatic logic [1:0] mskIdx(input logic [7:0] a);
    mskIdx = 2'(`PIC_OFF_MSK0 - a);
  endfunction : mskIdx

  // ************************************
  // next state
  // ************************************
  always_comb begin
    logic [NSRC-1:0] clrMask;
    logic [NSRC-1:0] setMask;
    logic [31:0]     rd;
    logic            req;
    int              base;
    clrMask = '0;
    setMask = '0;
    rd      = '0;
    req     = 1'b0;
    base    = 0;
    cur_nxt = cur_r;
    cur_nxt.push  = '0;
    cur_nxt.fClr  = 1'b0;
    cur_nxt.pLoad = 1'b0;
    cur_nxt.fLoad = 1'b0;
    cur_nxt.isrGo = 1'b0;
    cur_nxt.ack   = 1'b0;
    cur_nxt.global_irq_enable   = cpuFlags[0];
    // bus access: one-cycle waitrequest, answer on second edge
    if ((bus.read || bus.write) && !cur_r.ack) begin
      cur_nxt.ack = 1'b1;
      unique case (bus.addr)
        `PIC_OFF_CLR0, `PIC_OFF_CLR1, `PIC_OFF_CLR2: begin
          base = 8 * clrIdx(bus.addr);
          for (int b = 0; b < 8; b++) begin
            if (base + b < NSRC) begin
              rd[b] = cur_r.posted[base + b];
              if (bus.write && !cur_r.swPostEn && !bus.wdata[b]) begin
                clrMask[base + b] = 1'b1;
              end
              if (bus.write && cur_r.swPostEn && bus.wdata[b]) begin
                setMask[base + b] = 1'b1;
              end
            end
          end
        end
        `PIC_OFF_MSK0, `PIC_OFF_MSK1, `PIC_OFF_MSK2: begin
          base = 8 * mskIdx(bus.addr);
          for (int b = 0; b < 8; b++) begin
            if (base + b < NSRC) begin
              rd[b] = cur_r.mask[base + b];
              if (bus.write) begin
                cur_nxt.mask[base + b] = bus.wdata[b];
              end
            end
          end
        end
        `PIC_OFF_MSK3: begin
          rd[`PIC_SWPOST_BIT] = cur_r.swPostEn;
          if (bus.write) begin
            cur_nxt.swPostEn = bus.wdata[`PIC_SWPOST_BIT];
          end
        end
        `PIC_OFF_VC: begin
          rd[7:0] = anyPend ? winVec : `PIC_RST_BYTE;
          if (bus.write) begin
            clrMask = clrMask | pending;
          end
        end
        `PIC_OFF_PCSTAT: begin
          rd[2:0] = cur_r.st;
        end
        default: rd = '0;
      endcase
      cur_nxt.rdata = rd;
    end
    // taking an interrupt clears its latch
    if (cur_r.st == PIC_PUSHH) begin
      clrMask = clrMask | takenBit;
    end
    cur_nxt.posted = (cur_r.posted & ~clrMask) | setMask | srcEvent;
    // request goes active on event, unmask or enable rise while pending
    req = anyPend && cur_r.global_irq_enable;
    unique case (cur_r.st)
      PIC_IDLE, PIC_RUN: begin
        if (req && instrDone) begin
          cur_nxt.st      = PIC_PUSHH;
          cur_nxt.vec     = winVec;
          cur_nxt.savedPc = cpuPc;
          cur_nxt.savedFl = cpuFlags;
          cur_nxt.cnt     = 5'h01;
        end else if (retiExec) begin
          cur_nxt.pLoad = 1'b1;
          cur_nxt.pVal  = {popPcHigh, popPcLow};
          cur_nxt.fLoad = 1'b1;
          cur_nxt.fVal  = popFlags;
          cur_nxt.st    = PIC_IDLE;
        end
      end
      PIC_PUSHH: begin
        cur_nxt.push = '{valid: 1'b1, isWrite: 1'b1, data: cur_r.savedPc[15:8]};
        cur_nxt.st   = PIC_PUSHL;
        cur_nxt.cnt  = cur_r.cnt + 5'h01;
      end
      PIC_PUSHL: begin
        cur_nxt.push = '{valid: 1'b1, isWrite: 1'b1, data: cur_r.savedPc[7:0]};
        cur_nxt.st   = PIC_PUSHF;
        cur_nxt.cnt  = cur_r.cnt + 5'h01;
      end
      PIC_PUSHF: begin
        cur_nxt.push = '{valid: 1'b1, isWrite: 1'b1, data: cur_r.savedFl};
        cur_nxt.fClr = 1'b1;
        cur_nxt.st   = PIC_WAIT;
        cur_nxt.cnt  = cur_r.cnt + 5'h01;
      end
      PIC_WAIT: begin
        cur_nxt.cnt = cur_r.cnt + 5'h01;
        if (cur_r.cnt == `PIC_DISPATCH_CYC) begin
          cur_nxt.pLoad = 1'b1;
          cur_nxt.pVal  = {`PIC_RST_BYTE, cur_r.vec};
          cur_nxt.st    = PIC_JUMP;
          cur_nxt.cnt   = 5'h00;
        end
      end
      PIC_JUMP: begin
        cur_nxt.cnt = cur_r.cnt + 5'h01;
        if (cur_r.cnt == `PIC_LONG_JUMP_OP_CYC - 5'h01) begin
          cur_nxt.isrGo = 1'b1;
          cur_nxt.st    = PIC_RUN;
          cur_nxt.cnt   = 5'h00;
        end
      end
      default: cur_nxt.st = PIC_IDLE;
    endcase
    // busy covers the dispatch and the long jump, registered with the state
    cur_nxt.busy = (cur_nxt.st != PIC_IDLE) && (cur_nxt.st != PIC_RUN);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign avs_readdata    = cur_r.rdata;
  assign avs_waitrequest = !cur_r.ack;
  assign stackPush       = cur_r.push;
  assign flagsClear      = cur_r.fClr;
  assign pcLoad          = cur_r.pLoad;
  assign pcValue         = cur_r.pVal;
  assign flagsLoad       = cur_r.fLoad;
  assign flagsValue      = cur_r.fVal;
  assign dispatchBusy    = cur_r.busy;
  assign isrStart        = cur_r.isrGo;

  // ************************************
  // checks
  // ************************************
  sequence s_pushes;
    (stackPush.valid && stackPush.data == cur_r.savedPc[15:8])
      ##1 (stackPush.valid && stackPush.data == cur_r.savedPc[7:0])
      ##1 (stackPush.valid && stackPush.data == cur_r.savedFl);
  endsequence

  // dispatch plus long jump hold the core for twenty cycles
  sequence s_busy_span;
    dispatchBusy [*8] ##1 dispatchBusy [*8] ##1 dispatchBusy [*4] ##1 !dispatchBusy;
  endsequence

  sequence s_restore;
    pcLoad && flagsLoad && pcValue == $past({popPcHigh, popPcLow})
      && flagsValue == $past(popFlags);
  endsequence

  a_event_posts: assert property (@(posedge clk) disable iff (sys_rst)
    srcEvent[0] |=> cur_r.posted[0]) else $error("event not posted");
  a_mask_gates: assert property (@(posedge clk) disable iff (sys_rst)
    !cur_r.mask[0] |-> !pending[0]) else $error("masked source pending");
  a_no_take_off: assert property (@(posedge clk) disable iff (sys_rst)
    (cur_r.st == PIC_IDLE && !cur_r.global_irq_enable) |=> cur_r.st != PIC_PUSHH)
    else $error("taken while disabled");
  a_enable_takes: assert property (@(posedge clk) disable iff (sys_rst)
    ((cur_r.st == PIC_IDLE || cur_r.st == PIC_RUN) && cur_r.global_irq_enable && anyPend && instrDone)
    |=> cur_r.st == PIC_PUSHH) else $error("active request not taken");

  a_push_order: assert property (@(posedge clk) disable iff (sys_rst)
    cur_r.st == PIC_PUSHH |=> s_pushes) else $error("push sequence broken");
  a_flags_clear: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(stackPush.valid) |-> ##2 flagsClear) else $error("flags not cleared");
  a_vector_load: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(stackPush.valid) |-> ##12 (pcLoad && pcValue == {`PIC_RST_BYTE, cur_r.vec}))
    else $error("dispatch not 13 cycles");
  a_long_jump_op_len: assert property (@(posedge clk) disable iff (sys_rst)
    (pcLoad && cur_r.st == PIC_JUMP) |-> ##7 isrStart)
    else $error("long jump length wrong");
  a_busy_span: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(dispatchBusy) |-> s_busy_span) else $error("core hold length wrong");
  a_taken_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (cur_r.st == PIC_PUSHH && !avs_write && !(|(takenBit & srcEvent)))
    |=> !(|(cur_r.posted & $past(takenBit)))) else $error("taken latch kept");
  a_restore: assert property (@(posedge clk) disable iff (sys_rst)
    (retiExec && !dispatchBusy && !(cur_r.global_irq_enable && anyPend && instrDone))
    |=> s_restore) else $error("return did not restore");

  // register side
  a_answer_next: assert property (@(posedge clk) disable iff (sys_rst)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");
  a_stand_once: assert property (@(posedge clk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest) else $error("answer stood too long");
  a_read_posted: assert property (@(posedge clk) disable iff (sys_rst)
    (bus.read && bus.addr == `PIC_OFF_CLR0 && !cur_r.ack)
    |=> avs_readdata[7:0] == $past(cur_r.posted[7:0])) else $error("posted read wrong");
  a_zero_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (bus.write && bus.addr == `PIC_OFF_CLR0 && !cur_r.ack && !cur_r.swPostEn
      && !bus.wdata[0] && !srcEvent[0]) |=> !cur_r.posted[0]) else $error("zero did not clear");
  a_one_posts: assert property (@(posedge clk) disable iff (sys_rst)
    (bus.write && bus.addr == `PIC_OFF_CLR0 && !cur_r.ack && cur_r.swPostEn
      && bus.wdata[0]) |=> cur_r.posted[0]) else $error("one did not post");
  a_swpost_ignore0: assert property (@(posedge clk) disable iff (sys_rst)
    (cur_r.swPostEn && cur_r.posted[0] && cur_r.st == PIC_IDLE
      && !(bus.write && bus.addr == `PIC_OFF_VC)) |=> cur_r.posted[0])
    else $error("zero write cleared in post mode");
  a_mask_keeps: assert property (@(posedge clk) disable iff (sys_rst)
    (bus.write && bus.addr == `PIC_OFF_MSK0 && !cur_r.ack && !bus.wdata[0]
      && cur_r.posted[0] && cur_r.st != PIC_PUSHH) |=> cur_r.posted[0])
    else $error("mask write cleared latch");
  a_vc_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (bus.write && bus.addr == `PIC_OFF_VC && !cur_r.ack && srcEvent == '0)
    |=> pending == '0) else $error("vector write left pending");
endmodule : pic_controller

// *** testbench/pic_cpu_model.sv ***
// cpu core model: runs instructions, keeps the stack, flags and pc
`timescale 1ns/1ps
module pic_cpu_model
  import pic_pkg::*;
(
  input  wire logic        clk,          // system clock
  input  wire logic        sys_rst,      // async reset
  input  wire logic [3:0]  instrLen,     // cycles per instruction, less one
  input  wire logic        flagsWe,      // software writes flags
  input  wire logic [7:0]  flagsIn,      // flag value from software
  input  wire logic        retiReq,      // issue a return
  input  wire pic_push_t   stackPush,    // pushed byte
  input  wire logic        flagsClear,   // clear flags
  input  wire logic        pcLoad,       // load pc
  input  wire logic [15:0] pcValue,      // pc to load
  input  wire logic        flagsLoad,    // load flags
  input  wire logic [7:0]  flagsValue,   // flags to load
  input  wire logic        dispatchBusy, // core held
  output logic             instrDone,    // instruction finished
  output logic             retiExec,     // return executing
  output logic [15:0]      cpuPc,        // program counter
  output logic [7:0]       cpuFlags,     // flag register
  output logic [7:0]       popPcHigh,    // stacked pc high
  output logic [7:0]       popPcLow,     // stacked pc low
  output logic [7:0]       popFlags      // stacked flags
);
  logic [7:0] stk [0:15];
  logic [3:0] sp;
  logic [3:0] cnt;
  assign popFlags  = stk[sp-4'h1];
  assign popPcLow  = stk[sp-4'h2];
  assign popPcHigh = stk[sp-4'h3];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) stk[i] <= 8'hA5;
      sp <= 4'h0; cnt <= 4'h0; instrDone <= 1'b0; retiExec <= 1'b0;
      cpuPc <= 16'h1234; cpuFlags <= 8'h00;
    end else begin
      instrDone <= 1'b0;
      retiExec  <= retiReq & ~dispatchBusy;
      if (!dispatchBusy) begin
        cnt <= cnt + 4'h1;
        if (cnt >= instrLen) begin
          cnt <= 4'h0; instrDone <= 1'b1; cpuPc <= cpuPc + 16'h0001;
        end
      end
      if (stackPush.valid && stackPush.isWrite) begin
        stk[sp] <= stackPush.data; sp <= sp + 4'h1;
      end
      if (retiExec) sp <= sp - 4'h3;
      if (flagsWe) cpuFlags <= flagsIn;
      if (flagsClear) cpuFlags <= 8'h00;
      if (flagsLoad) cpuFlags <= flagsValue;
      if (pcLoad) cpuPc <= pcValue;
    end
  end
endmodule : pic_cpu_model

// *** testbench/pic_controller_tb.sv ***
// randomised self-checking bench of the interrupt controller
`timescale 1ns/1ps
`include "pic_defs.svh"
module pic_controller_tb;
  import pic_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00, flagsIn = 8'h00, w, fVal;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, instrDone, retiExec, flagsClear, pcLoad, flagsLoad;
  logic dispatchBusy, isrStart, flagsWe = 1'b0, retiReq = 1'b0;
  logic [23:0] srcEvent = 24'h0, posted = 24'h0, m;
  logic [15:0] cpuPc, pcValue, pcAt, pc0, ldVal, rPc;
  logic [7:0] cpuFlags, popPcHigh, popPcLow, popFlags, flagsValue;
  logic [3:0] instrLen = 4'h3;
  pic_push_t stackPush;
  logic [7:0] pushQ[$];
  int fail_count = 0, n_tests = 0, cyc = 0, tPush, tLoad, tIsr, k;
  always #50 clk = ~clk;
  pic_controller u_dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .srcEvent, .instrDone, .retiExec, .cpuPc, .cpuFlags,
    .popPcHigh, .popPcLow, .popFlags, .stackPush, .flagsClear, .pcLoad, .pcValue,
    .flagsLoad, .flagsValue, .dispatchBusy, .isrStart);
  pic_cpu_model u_cpu (.clk, .sys_rst, .instrLen, .flagsWe, .flagsIn, .retiReq, .stackPush,
    .flagsClear, .pcLoad, .pcValue, .flagsLoad, .flagsValue, .dispatchBusy, .instrDone,
    .retiExec, .cpuPc, .cpuFlags, .popPcHigh, .popPcLow, .popFlags);
  always @(posedge clk) begin
    cyc++;
    if (stackPush.valid === 1'b1) begin
      if (pushQ.size() % 3 == 0) begin tPush = cyc; pcAt = cpuPc; end
      pushQ.push_back(stackPush.data);
    end
    if (pcLoad === 1'b1) begin tLoad = cyc; ldVal = pcValue; end
    if (flagsLoad === 1'b1) begin fVal = flagsValue; rPc = pcValue; end
    if (isrStart === 1'b1) tIsr = cyc;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // one avalon transfer; ev pulses with the request so it meets the taking edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d,
                     input logic [23:0] ev, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a; avs_read <= ~wr; avs_write <= wr; avs_writedata <= {24'h0, d};
    srcEvent <= ev;
    do begin @(posedge clk); srcEvent <= 24'h0; n++; end
    while (avs_waitrequest !== 1'b0 && n < 40);
    r = avs_readdata;
    avs_read <= 1'b0; avs_write <= 1'b0;
    if (n >= 40) chk("waitrequest", 1'b1, 1'b0);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, 24'h0, r);
  endtask : wr
  task automatic rdClr;
    for (int i = 0; i < 3; i++) begin
      bus(8'hDA + 8'(i), 1'b0, 8'h00, 24'h0, q);
      chk("posted", q, {24'h0, posted[8*i +: 8]});
    end
  endtask : rdClr
  task automatic post(input logic [23:0] v);
    @(posedge clk); srcEvent <= v;
    @(posedge clk); srcEvent <= 24'h0;
    posted |= v;
  endtask : post
  function automatic logic [7:0] vecOf(input logic [23:0] p);
    for (int i = 0; i < 24; i++) if (p[i]) return 8'((i + 1) * 4);
    return 8'h00;
  endfunction : vecOf
  task automatic disp(input int d, input logic [7:0] fl, input logic [15:0] vec);
    tIsr = 0; k = 0;
    while (tIsr == 0 && k < 300) begin @(posedge clk); k++; end
    chk("isr", tIsr != 0, 1);
    chk("pushH", pushQ[3*d], pcAt[15:8]);
    chk("pushL", pushQ[3*d+1], pcAt[7:0]);
    chk("pushF", pushQ[3*d+2], fl);
    chk("vector", ldVal, vec);
    chk("dispatch", tLoad - tPush, 12);
    chk("long_jump_op", tIsr - tLoad, 7);
    chk("flags", cpuFlags, 8'h00);
  endtask : disp
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(25122));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      bus(8'hDA + 8'(i), 1'b0, 8'h00, 24'h0, q); chk("reset", q, 32'h0);
    end
    bus(8'hF0, 1'b0, 8'h00, 24'h0, q); chk("unmapped", q, 32'h0);
    repeat (6) begin
      instrLen <= 4'h2 + 4'($urandom % 6);
      post(24'($urandom) & 24'h7FFFFF);
      rdClr();
      k = $urandom % 3; w = 8'($urandom);
      wr(8'hDA + 8'(k), w); posted[8*k +: 8] &= w;
      rdClr();
      wr(`PIC_OFF_MSK3, 8'h80);
      k = $urandom % 3; w = 8'($urandom) & 8'h7F;
      wr(8'hDA + 8'(k), w); posted[8*k +: 8] |= w;
      wr(`PIC_OFF_MSK3, 8'h00);
      rdClr();
      m = 24'($urandom) & 24'h7FFFFF;
      for (int i = 0; i < 3; i++) wr(8'hE1 - 8'(i), m[8*i +: 8]);
      bus(`PIC_OFF_VC, 1'b0, 8'h00, 24'h0, q);
      chk("vcread", q, {24'h0, vecOf(posted & m)});
    end
    bus(`PIC_OFF_CLR0, 1'b1, 8'h00, 24'h000001, q);
    bus(`PIC_OFF_CLR0, 1'b0, 8'h00, 24'h0, q); chk("postwins", q, 32'h1);
    wr(`PIC_OFF_VC, 8'($urandom));
    bus(`PIC_OFF_VC, 1'b0, 8'h00, 24'h0, q); chk("vcclear", q, 32'h0);
    for (int i = 0; i < 3; i++) wr(8'hDA + 8'(i), 8'h00);
    for (int i = 0; i < 3; i++) wr(8'hE1 - 8'(i), 8'h00);
    instrLen <= 4'h3;
    wr(`PIC_OFF_MSK0, 8'h12);
    post(24'h000012);
    bus(`PIC_OFF_VC, 1'b0, 8'h00, 24'h0, q); chk("vcprio", q, 32'h8);
    @(posedge clk); flagsIn <= 8'h01; flagsWe <= 1'b1;
    @(posedge clk); flagsWe <= 1'b0;
    disp(0, 8'h01, 16'h0008);
    pc0 = pcAt;
    bus(`PIC_OFF_CLR0, 1'b0, 8'h00, 24'h0, q); chk("taken", q, 32'h10);
    @(posedge clk); retiReq <= 1'b1;
    @(posedge clk); retiReq <= 1'b0;
    disp(1, 8'h01, 16'h0014);
    chk("restore", {rPc, fVal}, {pc0, 8'h01});
    report_and_stop();
  end
endmodule : pic_controller_tb
